/* core/report_cmds.sv */
// Device-server interpreter for the timestamp and unit list reports.
// Assumes a whole CDB arrives in parallel, byte 0 in the top bits, and
// that the transport drains the byte stream with a valid/ready handshake.
`timescale 1ns/1ns
`include "report_cmds_regs.svh"

// What this block does
// RULE1: Timestamp report is A3h with action 0Fh.
// RULE2: Timestamp report returns current device clock.
// RULE3: Bytes 0-1 carry length 000Ah, big-endian.
// RULE4: Length field ignores allocation length.
// RULE5: Byte 2 holds origin code, rest zero.
// RULE6: Bytes 4-9 clock MSB first; 3,10,11 zero.
// RULE7: Unit list report is opcode A0h.
// RULE8: Unit list accepted despite other reservations.
// RULE9: Allocation below 16 gives illegal-field check.
// RULE10: Short allocation returns whole entries, no error.
// RULE11: Byte 2 selects which units are listed.
// RULE12: Selector 00h lists addressed units.
// RULE13: Selector 01h lists well-known units only.
// RULE14: Selector 02h lists every reachable unit.
// RULE15: Selector 10h lists administrative units only.
// RULE16: No matching units gives zero list length.
// RULE17: Unit zero only: length 8, entry zero.
// RULE18: Unknown selector gives illegal-field check.
module report_cmds #(
    parameter int TICK_CYCLES = `TS_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic cmd_valid_i,
    input wire logic [95:0] cdb_i,
    output logic cmd_ready_o,
    output report_cmds_pkg::byte_t data_o,
    output logic data_valid_o,
    output logic data_last_o,
    input wire logic data_ready_i,
    output logic done_o,
    output logic status_check_o,
    output logic not_mine_o,
    output logic [3:0] sense_key_o,
    output logic [7:0] asc_o,
    output logic [7:0] ascq_o
);
    import report_cmds_pkg::*;

    device_clock_if dc ();

    device_clock #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_clock (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .dc(dc)
    );

    // Picks byte n of the CDB; byte 0 sits in the top bits.
    function automatic byte_t cdb_byte(input logic [95:0] cdb, input int n);
        cdb_byte = cdb[8*(11-n) +: 8];
    endfunction

    // Big-endian allocation length held in CDB bytes 6 to 9.
    function automatic logic [31:0] alloc_len(input logic [95:0] cdb);
        alloc_len = {cdb_byte(cdb, 6), cdb_byte(cdb, 7),
                     cdb_byte(cdb, 8), cdb_byte(cdb, 9)};
    endfunction

    // Bytes to send: the whole list, or what fits, in whole 8-byte units
    // for the unit list so that no entry is ever cut in half.
    function automatic logic [4:0] xfer_bytes(input logic [31:0] alloc,
                                              input logic [4:0] total,
                                              input resp_kind_e kind);
        if (alloc >= {27'h0, total}) begin
            xfer_bytes = total;
        end else if (kind == KIND_UNITS) begin
            xfer_bytes = alloc[4:0] & 5'h18; // see RULE10
        end else begin
            xfer_bytes = alloc[4:0];
        end
    endfunction

    // Parameter data byte at index idx for the latched response.
    function automatic byte_t resp_byte(input resp_kind_e kind,
                                        input logic [3:0] idx,
                                        input stamp_t ts,
                                        input origin_t org,
                                        input byte_t list_len);
        resp_byte = 8'h00;
        if (kind == KIND_STAMP) begin
            case (idx)
                4'd1: resp_byte = `TS_DATA_LEN; // see RULE3 see RULE4
                4'd2: resp_byte = {5'h00, org}; // see RULE5
                4'd4: resp_byte = ts[47:40]; // see RULE6
                4'd5: resp_byte = ts[39:32];
                4'd6: resp_byte = ts[31:24];
                4'd7: resp_byte = ts[23:16];
                4'd8: resp_byte = ts[15:8];
                4'd9: resp_byte = ts[7:0];
                default: resp_byte = 8'h00;
            endcase
        end else if (idx == 4'd3) begin
            // Entry bytes 8..15 stay zero: the only unit is unit zero.
            resp_byte = list_len; // see RULE17
        end
    endfunction

    cmd_state_e state;
    resp_kind_e kind;
    stamp_t snap_ts;
    origin_t snap_org;
    byte_t unit_list_byte_count;
    logic [4:0] xfer_len;
    logic [3:0] idx;
    logic run_en;
    logic [31:0] set_lo;
    logic [15:0] now_hi_shadow;
    logic [2:0] now_org_shadow;
    logic last_check;
    byte_t last_op;
    logic [31:0] handled_cnt;
    logic take_cmd;
    logic apb_setup;
    logic apb_write;
    logic addr_hit;
    logic byte_taken;

    // Decoded command fields.
    byte_t op;
    byte_t sel;
    logic [31:0] alloc;
    logic is_stamp;
    logic is_units;
    logic sel_ok;
    byte_t sel_count;

    assign op = cdb_byte(cdb_i, 0);
    assign sel = cdb_byte(cdb_i, 2); // see RULE11
    assign alloc = alloc_len(cdb_i);
    assign take_cmd = cmd_valid_i && cmd_ready_o;
    assign byte_taken = data_valid_o && data_ready_i;

    // Opcode plus the low five bits of byte 1 name the timestamp report.
    assign is_stamp = (op == `OP_MAINT_IN)
        && (cdb_byte(cdb_i, 1) & 8'h1f) == {3'h0, `SA_TIMESTAMP}; // see RULE1
    // No reservation input is consulted here, so the unit list is never
    // turned away by another initiator's reservation.
    assign is_units = (op == `OP_REPORT_UNITS); // see RULE7 see RULE8

    // Selector filter. Unit zero uses peripheral addressing, so it shows
    // under 00h and 02h; it is neither well known nor administrative.
    always_comb begin
        sel_ok = 1'b1;
        sel_count = 8'h00; // see RULE16
        case (sel)
            `SEL_ADDRESSED: sel_count = `UNIT_ENTRY_BYTES; // see RULE12
            `SEL_WELL_KNOWN: sel_count = 8'h00; // see RULE13
            `SEL_ALL: sel_count = `UNIT_ENTRY_BYTES; // see RULE14
            `SEL_ADMIN: sel_count = 8'h00; // see RULE15
            default: sel_ok = 1'b0; // see RULE18
        endcase
    end

    // Command sequencer: latch the answer at acceptance so that a clock
    // tick during the transfer cannot tear the six timestamp bytes.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            kind <= KIND_STAMP;
            snap_ts <= 48'h0000_0000_0000;
            snap_org <= 3'h0;
            unit_list_byte_count <= 8'h00;
            xfer_len <= 5'h00;
            idx <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take_cmd && is_stamp) begin
                        kind <= KIND_STAMP;
                        snap_ts <= dc.now; // see RULE2
                        snap_org <= dc.origin;
                        xfer_len <= xfer_bytes(alloc, `TS_TOTAL_BYTES, KIND_STAMP);
                        idx <= 4'h0;
                        state <= (alloc == 32'h0) ? ST_FINISH : ST_SEND;
                    end else if (take_cmd && is_units && sel_ok
                                 && alloc >= `UNIT_MIN_ALLOC) begin
                        kind <= KIND_UNITS;
                        unit_list_byte_count <= sel_count;
                        xfer_len <= xfer_bytes(alloc,
                            `UNIT_HDR_BYTES + sel_count[4:0], KIND_UNITS);
                        idx <= 4'h0;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (byte_taken) begin
                        idx <= idx + 4'h1;
                        if (data_last_o) begin
                            state <= ST_FINISH;
                        end
                    end
                end
                ST_FINISH: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // A new command is taken only while idle; ready drops the cycle after.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_ready_o <= 1'b0;
        end else begin
            cmd_ready_o <= (state == ST_IDLE) && !take_cmd;
        end
    end

    // Output byte register; loads the next byte whenever the slot is free.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_o <= 8'h00;
            data_valid_o <= 1'b0;
            data_last_o <= 1'b0;
        end else if (state == ST_SEND && (!data_valid_o || data_ready_i)) begin
            if (data_valid_o && data_last_o) begin
                data_valid_o <= 1'b0;
                data_last_o <= 1'b0;
            end else begin
                data_o <= resp_byte(kind, idx + {3'h0, data_valid_o},
                                    snap_ts, snap_org, unit_list_byte_count);
                data_valid_o <= 1'b1;
                data_last_o <= ({1'b0, idx} + {4'h0, data_valid_o} + 5'h01)
                               == xfer_len;
            end
        end else if (state != ST_SEND) begin
            data_valid_o <= 1'b0;
            data_last_o <= 1'b0;
        end
    end

    // Completion: good after the stream, check at once for a bad field,
    // and a pass-on marker for any opcode this block does not serve.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o <= 1'b0;
            status_check_o <= 1'b0;
            not_mine_o <= 1'b0;
            sense_key_o <= 4'h0;
            asc_o <= 8'h00;
            ascq_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            not_mine_o <= 1'b0;
            if (take_cmd && is_units
                && (!sel_ok || alloc < `UNIT_MIN_ALLOC)) begin
                done_o <= 1'b1; // see RULE9 see RULE18
                status_check_o <= 1'b1;
                sense_key_o <= `SENSE_ILLEGAL;
                asc_o <= `ASC_BAD_CDB;
                ascq_o <= `ASCQ_BAD_CDB;
            end else if (take_cmd && !is_units && !is_stamp) begin
                not_mine_o <= 1'b1;
            end else if (state == ST_FINISH) begin
                done_o <= 1'b1;
                status_check_o <= 1'b0;
                sense_key_o <= 4'h0;
                asc_o <= 8'h00;
                ascq_o <= 8'h00;
            end
        end
    end

    // Observable history for software.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_check <= 1'b0;
            last_op <= 8'h00;
            handled_cnt <= 32'h0000_0000;
        end else if (take_cmd && (is_units || is_stamp)) begin
            last_op <= op;
            last_check <= is_units && (!sel_ok || alloc < `UNIT_MIN_ALLOC);
            handled_cnt <= handled_cnt + 32'h0000_0001;
        end
    end

    // APB slave: zero wait states, pready answers in the first access cycle.
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pready_o && pwrite_i;
    assign addr_hit = (paddr_i == `REG_CTRL) || (paddr_i == `REG_STATUS)
        || (paddr_i == `REG_SET_LO) || (paddr_i == `REG_SET_HI)
        || (paddr_i == `REG_NOW_LO) || (paddr_i == `REG_NOW_HI)
        || (paddr_i == `REG_COUNT);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup && !addr_hit;
        end
    end

    // Read data is latched in the setup cycle. Reading the low time word
    // freezes the high word so a carry between the two reads cannot tear.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0000_0000;
            now_hi_shadow <= 16'h0000;
            now_org_shadow <= 3'h0;
        end else if (apb_setup && !pwrite_i) begin
            case (paddr_i)
                `REG_CTRL: prdata_o <= {31'h0, run_en};
                `REG_STATUS: prdata_o <= {16'h0, last_op, 6'h0, last_check,
                                          state != ST_IDLE};
                `REG_SET_LO: prdata_o <= set_lo;
                `REG_NOW_LO: begin
                    prdata_o <= dc.now[31:0];
                    now_hi_shadow <= dc.now[47:32];
                    now_org_shadow <= dc.origin;
                end
                `REG_NOW_HI: prdata_o <= {13'h0, now_org_shadow, now_hi_shadow};
                `REG_COUNT: prdata_o <= handled_cnt;
                default: prdata_o <= 32'h0000_0000;
            endcase
        end else if (apb_setup) begin
            prdata_o <= 32'h0000_0000;
        end
    end

    // Control writes; writing the high word loads the clock and its origin.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_en <= 1'(`CTRL_RESET >> `CTRL_RUN_BIT);
            set_lo <= 32'h0000_0000;
            dc.load <= 1'b0;
            dc.load_value <= 48'h0000_0000_0000;
            dc.load_origin <= 3'h0;
        end else begin
            dc.load <= 1'b0;
            if (apb_write && paddr_i == `REG_CTRL) begin
                run_en <= pwdata_i[`CTRL_RUN_BIT];
            end
            if (apb_write && paddr_i == `REG_SET_LO) begin
                set_lo <= pwdata_i;
            end
            if (apb_write && paddr_i == `REG_SET_HI) begin
                dc.load <= 1'b1;
                dc.load_value <= {pwdata_i[15:0], set_lo};
                dc.load_origin <= pwdata_i[`HI_ORIGIN_LSB +: 3];
            end
        end
    end

    assign dc.run = run_en;
endmodule

/* core/report_cmds_regs.svh */
// Register offsets, field positions, reset values and timing counts.
// Assumes a 32-bit APB with byte addresses and a 250 MHz system clock.
`ifndef REPORT_CMDS_REGS_SVH
`define REPORT_CMDS_REGS_SVH

// Register byte offsets.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SET_LO 12'h008
`define REG_SET_HI 12'h00c
`define REG_NOW_LO 12'h010
`define REG_NOW_HI 12'h014
`define REG_COUNT 12'h018

// Field positions.
`define CTRL_RUN_BIT 0
`define HI_ORIGIN_LSB 16
`define STAT_BUSY_BIT 0
`define STAT_CHECK_BIT 1
`define STAT_LAST_OP_LSB 8

// Reset values.
`define CTRL_RESET 32'h0000_0001

// Command decode values.
`define OP_MAINT_IN 8'ha3
`define SA_TIMESTAMP 5'h0f
`define OP_REPORT_UNITS 8'ha0
`define SEL_ADDRESSED 8'h00
`define SEL_WELL_KNOWN 8'h01
`define SEL_ALL 8'h02
`define SEL_ADMIN 8'h10

// Parameter data layout.
`define TS_DATA_LEN 8'h0a
`define TS_TOTAL_BYTES 5'd12
`define UNIT_ENTRY_BYTES 8'h08
`define UNIT_MIN_ALLOC 32'd16
`define UNIT_HDR_BYTES 5'd8

// Sense data for a refused request.
`define SENSE_ILLEGAL 4'h5
`define ASC_BAD_CDB 8'h24
`define ASCQ_BAD_CDB 8'h00

// Device clock counts milliseconds.
`define CLK_PERIOD_PS 4000
`define TS_TICK_NS 1000000
`define TS_TICK_CYCLES ((`TS_TICK_NS * 1000) / `CLK_PERIOD_PS)

`endif

/* core/report_cmds_pkg.sv */
// Types shared by the command interpreter and its device clock.
// Assumes the constants of report_cmds_regs.svh are included where used.
package report_cmds_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [47:0] stamp_t;
    typedef logic [2:0] origin_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_FINISH
    } cmd_state_e;

    typedef enum logic {
        KIND_STAMP,
        KIND_UNITS
    } resp_kind_e;

endpackage

/* core/device_clock_if.sv */
// Connection between the interpreter and its 48-bit device clock.
// Assumes both ends share clk_i; load is a one-cycle pulse.
`timescale 1ns/1ns
interface device_clock_if;
    import report_cmds_pkg::*;

    logic load;
    stamp_t load_value;
    origin_t load_origin;
    logic run;
    stamp_t now;
    origin_t origin;

    // The interpreter owns loading and running; the counter owns the time.
    modport owner (
        output load,
        output load_value,
        output load_origin,
        output run,
        input now,
        input origin
    );
    modport counter (
        input load,
        input load_value,
        input load_origin,
        input run,
        output now,
        output origin
    );
endinterface

/* core/device_clock.sv */
// Millisecond device clock with the origin of its last initialisation.
// Assumes a single clock domain and an owner that pulses load.
`timescale 1ns/1ns
`include "report_cmds_regs.svh"
module device_clock #(
    parameter int TICK_CYCLES = `TS_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    device_clock_if.counter dc
);
    import report_cmds_pkg::*;
    logic [31:0] tick_cnt;
    logic tick;

    // Divider gives a one-cycle enable once per millisecond.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

    // A load wins over a tick so that software sees exactly what it wrote.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dc.now <= 48'h0000_0000_0000;
            dc.origin <= 3'h0; // Zero marks a clock started from reset.
        end else if (dc.load) begin
            dc.now <= dc.load_value;
            dc.origin <= dc.load_origin;
        end else if (dc.run && tick) begin
            dc.now <= dc.now + 48'h0000_0000_0001;
        end
    end
endmodule

/* verification/report_cmds_props.sv */
// Checker on the interpreter's command, stream and completion ports.
// Assumes it is bound into report_cmds and shares its clock and reset.
`timescale 1ns/1ns
module report_cmds_props #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_valid_i,
    input wire logic [95:0] cdb_i,
    input wire logic cmd_ready_o,
    input wire report_cmds_pkg::byte_t data_o,
    input wire logic data_valid_o,
    input wire logic data_last_o,
    input wire logic data_ready_i,
    input wire logic done_o,
    input wire logic status_check_o,
    input wire logic not_mine_o,
    input wire logic [3:0] sense_key_o,
    input wire logic [7:0] asc_o,
    input wire logic [7:0] ascq_o
);
    import report_cmds_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Takes of each command kind; a unit list take is refused on length or selector.
    sequence ts_take;
        cmd_valid_i && cmd_ready_o && cdb_i[95:88] == 8'ha3 && cdb_i[84:80] == 5'h0f
            && cdb_i[47:16] != 32'h0;
    endsequence
    sequence bad_unit_take;
        cmd_valid_i && cmd_ready_o && cdb_i[95:88] == 8'ha0 && (cdb_i[47:16] < 32'h10
            || !(cdb_i[79:72] inside {8'h00, 8'h01, 8'h02, 8'h10}));
    endsequence
    sequence foreign_take;
        cmd_valid_i && cmd_ready_o && cdb_i[95:88] != 8'ha0
            && !(cdb_i[95:88] == 8'ha3 && cdb_i[84:80] == 5'h0f);
    endsequence
    sequence last_taken;
        data_valid_o && data_ready_i && data_last_o;
    endsequence

    a_take_drops: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
        else $error("command ready stayed high after a take");
    a_refuse_check: assert property (bad_unit_take |=> done_o && status_check_o)
        else $error("refused unit list did not end with check");
    a_check_sense: assert property (done_o && status_check_o |-> sense_key_o == 4'h5
        && asc_o == 8'h24 && ascq_o == 8'h00)
        else $error("wrong sense on a check ending");
    a_good_sense: assert property (done_o && !status_check_o |-> sense_key_o == 4'h0
        && asc_o == 8'h00)
        else $error("sense set on a good ending");
    a_ts_first: assert property (ts_take |-> ##2 data_valid_o && data_o == 8'h00)
        else $error("timestamp data did not start with zero length byte");
    a_byte_hold: assert property (data_valid_o && !data_ready_i |=> data_valid_o
        && $stable(data_o) && $stable(data_last_o))
        else $error("stalled byte changed");
    a_done_last: assert property (last_taken |-> ##2 done_o && !status_check_o)
        else $error("no good ending after last byte");
    a_foreign_pulse: assert property (foreign_take |=> not_mine_o && !done_o)
        else $error("foreign command not handed on");
    a_ready_back: assert property (done_o |=> cmd_ready_o)
        else $error("command ready did not return after an ending");
endmodule

bind report_cmds report_cmds_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cdb_i(cdb_i),
    .cmd_ready_o(cmd_ready_o), .data_o(data_o), .data_valid_o(data_valid_o),
    .data_last_o(data_last_o), .data_ready_i(data_ready_i), .done_o(done_o),
    .status_check_o(status_check_o), .not_mine_o(not_mine_o), .sense_key_o(sense_key_o),
    .asc_o(asc_o), .ascq_o(ascq_o));

/* verification/scsi_initiator_model.sv */
// Initiator model: hands over one CDB at a time and sinks the parameter bytes.
// Assumes the bench calls issue and sets stall; one clock with the block.
`timescale 1ns/1ns
module scsi_initiator_model (
    input wire logic clk_i,
    input wire logic cmd_ready_i,
    input wire report_cmds_pkg::byte_t data_i,
    input wire logic data_valid_i,
    input wire logic data_last_i,
    input wire logic done_i,
    input wire logic status_check_i,
    input wire logic not_mine_i,
    output logic cmd_valid_o,
    output logic [95:0] cdb_o,
    output logic data_ready_o
);
    import report_cmds_pkg::*;
    byte_t got[$];
    logic stall = 1'b0;

    initial begin
        cmd_valid_o = 1'b0;
        cdb_o = '0;
        data_ready_o = 1'b1;
    end

    // Collect taken bytes; a stalling sink toggles ready to test the hold.
    always @(posedge clk_i) begin
        if (data_valid_i && data_ready_o) begin
            got.push_back(data_i);
        end
        data_ready_o <= stall ? ~data_ready_o : 1'b1;
    end

    // Hold the CDB until taken, then scramble it so stale bytes cannot pass.
    task automatic issue(input logic [95:0] cdb, output logic chk, output logic foreign);
        got.delete();
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cdb_o <= cdb;
        @(posedge clk_i);
        while (cmd_ready_i !== 1'b1) begin
            @(posedge clk_i);
        end
        cmd_valid_o <= 1'b0;
        cdb_o <= ~cdb;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (done_i === 1'b1 || not_mine_i === 1'b1) begin
                break;
            end
        end
        chk = done_i & status_check_i;
        foreign = not_mine_i;
    endtask
endmodule

/* verification/report_cmds_tb_top.sv */
// Bench for the report interpreter: APB set-up, then command sequences.
// Assumes the initiator model and the bound checker sit beside the block.
`timescale 1ns/1ns
module report_cmds_tb_top;
    import report_cmds_pkg::*;
    logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic cmd_valid_i, cmd_ready_o, data_valid_o, data_last_o, data_ready_i;
    logic done_o, status_check_o, not_mine_o;
    logic [95:0] cdb_i;
    byte_t data_o;
    logic [3:0] sense_key_o;
    logic [7:0] asc_o, ascq_o;
    int fail_count = 0;
    int samples_checked = 0;
    // Images of full parameter data, byte 0 in the top bits.
    localparam logic [127:0] TS = {16'h000a, 8'h05, 8'h00, 48'h1234_89ab_cdef, 48'h0};
    localparam logic [127:0] LU8 = {24'h0, 8'h08, 96'h0};
    localparam logic [7:0] SELS [4] = '{8'h00, 8'h01, 8'h02, 8'h10};

    report_cmds #(.TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .cmd_valid_i(cmd_valid_i), .cdb_i(cdb_i), .cmd_ready_o(cmd_ready_o), .data_o(data_o),
        .data_valid_o(data_valid_o), .data_last_o(data_last_o), .data_ready_i(data_ready_i),
        .done_o(done_o), .status_check_o(status_check_o), .not_mine_o(not_mine_o),
        .sense_key_o(sense_key_o), .asc_o(asc_o), .ascq_o(ascq_o));
    scsi_initiator_model ini (.clk_i(clk_i), .cmd_ready_i(cmd_ready_o), .data_i(data_o),
        .data_valid_i(data_valid_o), .data_last_i(data_last_o), .done_i(done_o),
        .status_check_i(status_check_o), .not_mine_i(not_mine_o), .cmd_valid_o(cmd_valid_i),
        .cdb_o(cdb_i), .data_ready_o(data_ready_i));

    // A 4 ns clock for the 250 MHz system domain.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // One APB transfer; the wait ends only on pready, the watchdog guards a hang.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    function automatic logic [95:0] mk(input byte_t op, b1, b2, input logic [31:0] alloc);
        return {op, b1, b2, 24'h0, alloc, 16'h0};
    endfunction

    // Issue one command and compare ending kind and every returned byte.
    task automatic do_cmd(input logic [95:0] cdb, input int n, input logic [127:0] img,
                          input logic exp_chk, input logic exp_foreign);
        logic c, f;
        ini.issue(cdb, c, f);
        chk("check status", {31'h0, exp_chk}, {31'h0, c});
        chk("foreign pulse", {31'h0, exp_foreign}, {31'h0, f});
        chk("byte count", n, ini.got.size());
        for (int i = 0; i < n; i++) begin
            chk("param byte", {24'h0, img[127 - 8 * i -: 8]}, {24'h0, ini.got[i]});
        end
    endtask

    // Tests take about 200 cycles; 25000 cycles means a hang.
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end

    initial begin
        logic [31:0] rd;
        logic er;
        rst_b_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = '0;
        pwdata_i = '0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, rd, er);
        chk("ctrl reset", 32'h1, rd);
        apb(1'b0, 12'h020, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        // Stop the clock so the loaded value is still there when reported.
        apb(1'b1, 12'h000, 32'h0, rd, er);
        apb(1'b1, 12'h008, 32'h89ab_cdef, rd, er);
        apb(1'b1, 12'h00c, 32'h0005_1234, rd, er);
        apb(1'b0, 12'h010, 32'h0, rd, er);
        chk("clock low word", 32'h89ab_cdef, rd);
        do_cmd(mk(8'ha3, 8'h0f, 8'h00, 32'd12), 12, TS, 1'b0, 1'b0);
        ini.stall = 1'b1;
        do_cmd(mk(8'ha3, 8'h0f, 8'h00, 32'd5), 5, TS, 1'b0, 1'b0);
        ini.stall = 1'b0;
        do_cmd(mk(8'ha3, 8'h0f, 8'h00, 32'd0), 0, TS, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            do_cmd(mk(8'ha0, 8'h00, SELS[i], 32'd16), SELS[i][0] | SELS[i][4] ? 8 : 16,
                   SELS[i][0] | SELS[i][4] ? 128'h0 : LU8, 1'b0, 1'b0);
        end
        do_cmd(mk(8'ha0, 8'h00, 8'h02, 32'd20), 16, LU8, 1'b0, 1'b0);
        do_cmd(mk(8'ha0, 8'h00, 8'h00, 32'd15), 0, LU8, 1'b1, 1'b0);
        do_cmd(mk(8'ha0, 8'h00, 8'h03, 32'd16), 0, LU8, 1'b1, 1'b0);
        do_cmd(mk(8'ha0, 8'h00, 8'h11, 32'd16), 0, LU8, 1'b1, 1'b0);
        do_cmd(mk(8'ha3, 8'h0e, 8'h00, 32'd12), 0, TS, 1'b0, 1'b1);
        do_cmd(mk(8'h12, 8'h00, 8'h00, 32'd12), 0, TS, 1'b0, 1'b1);
        stop_test();
    end
endmodule
